// [hw/gtfc_pkg.sv]
// package: register map, fields and reset values of the gain/filter bank
package gtfc_pkg;
   // ------------------------------------------------------------------
   // register offsets (32-bit word indices on avs_address, not byte offsets)
   // ------------------------------------------------------------------
   localparam logic [11:0] FINE_GAIN_A0_IDX     = 12'h354;
   localparam logic [11:0] FINE_GAIN_A1_IDX     = 12'h355;
   localparam logic [11:0] FINE_GAIN_B0_IDX     = 12'h356;
   localparam logic [11:0] FINE_GAIN_B1_IDX     = 12'h357;
   localparam logic [11:0] FILTER_CTRL_IDX      = 12'h400;
   localparam logic [11:0] COEF_A_TAP0_IDX      = 12'h418;
   localparam logic [11:0] FILTER_STATUS_IDX    = 12'h401;
   localparam logic [11:0] LINK_CTRL_IDX        = 12'h402;
   // ------------------------------------------------------------------
   // field positions and widths
   // ------------------------------------------------------------------
   localparam int TRIM_W          = 5;
   localparam int SHARE_BIT       = 6;
   localparam int MERGE_BIT       = 5;
   localparam int SCW_LSB         = 2;
   localparam int SCW_W           = 3;
   localparam int MODE_LSB        = 0;
   localparam int MODE_W          = 2;
   localparam int COEF_W          = 12;
   localparam int NUM_TRIM        = 4;
   // ------------------------------------------------------------------
   // reset values and encodings
   // ------------------------------------------------------------------
   localparam logic [7:0]  FILTER_CTRL_RST  = 8'h00;
   localparam logic [4:0]  TRIM_RST         = 5'h00;
   localparam logic [11:0] COEF_RST         = 12'h000;
   localparam logic [1:0]  MODE_OFF         = 2'h0;
   localparam logic [1:0]  MODE_ON          = 2'h2;
   localparam logic [2:0]  SCW_MAX          = 3'h6;
   localparam logic [4:0]  SCW_EXP_BIAS     = 5'h10;
   localparam logic [31:0] UNMAPPED_DATA    = 32'h0000_0000;

   typedef enum logic [2:0] {
      GTFC_IDLE  = 3'b001,
      GTFC_LOAD  = 3'b010,
      GTFC_READY = 3'b100
   } gtfc_state_t;
endpackage

// [hw/gtfc_fuse_mem.sv]
// fuse storage image: factory trim words, registered read port
`timescale 1ns/1ps
`default_nettype none
module gtfc_fuse_mem #(
   parameter int DEPTH = 4,
   parameter int WIDTH = 5,
   parameter logic [19:0] INIT = 20'h00000
) (
   input  wire logic                     clock,
   input  wire logic                     arst_n,
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic      [WIDTH-1:0]         rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] rd_data_nxt;

   // fuses are read-only: contents fixed by the init image
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_fuse
         assign mem[g] = INIT[g*WIDTH +: WIDTH];
      end
   endgenerate

   always_comb begin
      rd_data_nxt = mem[rd_addr];
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rd_data <= '0;
      end else begin
         rd_data <= rd_data_nxt;
      end
   end
endmodule
`default_nettype wire

// [hw/gtfc_bank.sv]
// gain trim and equaliser filter configuration register bank
`timescale 1ns/1ps
`default_nettype none
module gtfc_bank
   import gtfc_pkg::*;
#(
   parameter logic [19:0] FUSE_TRIM_INIT = 20'h00000
) (
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire logic [13:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic [4:0]       trim_a_bank0,
   output logic [4:0]       trim_a_bank1,
   output logic [4:0]       trim_b_bank0,
   output logic [4:0]       trim_b_bank1,
   output logic             filter_enable,
   output logic             coef_share_enable,
   output logic             filter_merge_enable,
   output logic [2:0]       side_coef_weight,
   output logic [4:0]       side_lsb_exp_neg,
   output logic [11:0]      coef_a_tap0,
   output logic [11:0]      coef_b_tap0,
   output logic             trim_ready
);
   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   gtfc_state_t      state_r, state_nxt;
   logic [1:0]       fuse_idx_r, fuse_idx_nxt;
   logic [1:0]       fuse_rd_addr;
   logic [4:0]       fuse_data;
   logic [4:0]       trim_r   [NUM_TRIM];
   logic [4:0]       trim_nxt [NUM_TRIM];
   logic [7:0]       ctrl_r, ctrl_nxt;
   logic [11:0]      coef_a_r, coef_a_nxt;
   logic [11:0]      coef_b_r, coef_b_nxt;
   logic             link_en_r, link_en_nxt;
   logic             cfg_err_r, cfg_err_nxt;
   logic             ack_r, ack_nxt;
   logic [31:0]      rdata_r, rdata_nxt;
   logic [11:0]      idx;
   logic             req;

   assign idx = avs_address[11:0];
   assign req = (avs_read | avs_write) & ~ack_r;

   // ------------------------------------------------------------------
   // fuse storage
   // ------------------------------------------------------------------
   gtfc_fuse_mem #(
      .DEPTH (NUM_TRIM),
      .WIDTH (TRIM_W),
      .INIT  (FUSE_TRIM_INIT)
   ) u_fuse (
      .clock   (clock),
      .arst_n  (arst_n),
      .rd_addr (fuse_rd_addr),
      .rd_data (fuse_data)
   );

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic logic [7:0] lane_merge(input logic [7:0] old_v,
                                             input logic [7:0] new_v,
                                             input logic       en);
      lane_merge = en ? new_v : old_v;
   endfunction

   function automatic logic is_trim(input logic [11:0] a);
      is_trim = (a >= FINE_GAIN_A0_IDX) && (a <= FINE_GAIN_B1_IDX);
   endfunction

   // ------------------------------------------------------------------
   // fuse load sequencer
   // ------------------------------------------------------------------
   // read address leads the registered data by one cycle
   always_comb begin
      state_nxt    = state_r;
      fuse_idx_nxt = fuse_idx_r;
      fuse_rd_addr = fuse_idx_r;
      case (state_r)
         GTFC_IDLE: begin
            state_nxt    = GTFC_LOAD;
            fuse_idx_nxt = 2'h0;
         end
         GTFC_LOAD: begin
            fuse_idx_nxt = fuse_idx_r + 2'h1;
            if (fuse_idx_r == 2'h3) begin
               state_nxt = GTFC_READY;
            end
         end
         GTFC_READY: begin
            // park off zero so the READY load of the last trim happens exactly once (LOAD also writes it once, with fuse word 0)
            fuse_idx_nxt = 2'h1;
         end
         default: begin
            state_nxt = GTFC_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // register file next state
   // ------------------------------------------------------------------
   always_comb begin
      logic [1:0] t;
      logic       wr;
      t           = idx[1:0];
      // writes land at the edge where waitrequest is low
      wr          = avs_write & ack_r;
      trim_nxt    = trim_r;
      ctrl_nxt    = ctrl_r;
      coef_a_nxt  = coef_a_r;
      coef_b_nxt  = coef_b_r;
      link_en_nxt = link_en_r;
      cfg_err_nxt = cfg_err_r;
      ack_nxt     = req;
      rdata_nxt   = UNMAPPED_DATA;
      if (state_r == GTFC_LOAD) begin
         trim_nxt[fuse_idx_r - 2'h1] = fuse_data;
      end
      if (state_r == GTFC_READY && fuse_idx_r == 2'h0) begin
         trim_nxt[2'h3] = fuse_data;
      end
      if (wr) begin
         if (is_trim(idx)) begin
            if (avs_byteenable[0]) begin
               trim_nxt[t] = avs_writedata[4:0];
            end
         end else if (idx == FILTER_CTRL_IDX) begin
            if (link_en_r) begin
               cfg_err_nxt = 1'b1;
            end
            ctrl_nxt = lane_merge(ctrl_r, avs_writedata[7:0],
                                  avs_byteenable[0]);
            ctrl_nxt[7] = 1'b0;
         end else if (idx == COEF_A_TAP0_IDX) begin
            if (link_en_r) begin
               cfg_err_nxt = 1'b1;
            end
            if (avs_byteenable[0]) begin
               coef_a_nxt[7:0] = avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
               coef_a_nxt[11:8] = avs_writedata[11:8];
            end
         end else if (idx == LINK_CTRL_IDX) begin
            if (avs_byteenable[0]) begin
               link_en_nxt = avs_writedata[0];
            end
         end else if (idx == FILTER_STATUS_IDX) begin
            if (avs_byteenable[0] && avs_writedata[0]) begin
               cfg_err_nxt = 1'b0;
            end
         end
      end
      coef_b_nxt = ctrl_nxt[SHARE_BIT] ? coef_a_nxt : COEF_RST;
      if (req & avs_read) begin
         if (is_trim(idx)) begin
            rdata_nxt = {27'h0, trim_r[t]};
         end else if (idx == FILTER_CTRL_IDX) begin
            rdata_nxt = {24'h0, ctrl_r};
         end else if (idx == COEF_A_TAP0_IDX) begin
            rdata_nxt = {20'h0, 1'b0, coef_a_r[10:0]};
         end else if (idx == FILTER_STATUS_IDX) begin
            rdata_nxt = {28'h0, (state_r == GTFC_READY), filter_enable,
                         (ctrl_r[1:0] == 2'h1 || ctrl_r[1:0] == 2'h3),
                         cfg_err_r};
         end else if (idx == LINK_CTRL_IDX) begin
            rdata_nxt = {31'h0, link_en_r};
         end
      end
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_r    <= GTFC_IDLE;
         fuse_idx_r <= 2'h0;
         for (int i = 0; i < NUM_TRIM; i++) begin
            trim_r[i] <= TRIM_RST;
         end
         ctrl_r     <= FILTER_CTRL_RST;
         coef_a_r   <= COEF_RST;
         coef_b_r   <= COEF_RST;
         link_en_r  <= 1'b0;
         cfg_err_r  <= 1'b0;
         ack_r      <= 1'b0;
         rdata_r    <= UNMAPPED_DATA;
      end else begin
         state_r    <= state_nxt;
         fuse_idx_r <= fuse_idx_nxt;
         trim_r     <= trim_nxt;
         ctrl_r     <= ctrl_nxt;
         coef_a_r   <= coef_a_nxt;
         coef_b_r   <= coef_b_nxt;
         link_en_r  <= link_en_nxt;
         cfg_err_r  <= cfg_err_nxt;
         ack_r      <= ack_nxt;
         rdata_r    <= rdata_nxt;
      end
   end

   // ------------------------------------------------------------------
   // outputs: all from flip-flops except avs_waitrequest, decoded from avs_read/avs_write and ack_r, and trim_ready, decoded from state_r and fuse_idx_r
   // ------------------------------------------------------------------
   logic [4:0] exp_r;
   logic       en_r;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         exp_r <= SCW_EXP_BIAS;
         en_r  <= 1'b0;
      end else begin
         // side lsb weight 2^-(16-scw), clamped at 6
         exp_r <= SCW_EXP_BIAS - {2'h0,
                  (ctrl_nxt[4:2] > SCW_MAX) ? SCW_MAX : ctrl_nxt[4:2]};
         // only mode 2 enables the filter
         en_r  <= (ctrl_nxt[1:0] == MODE_ON);
      end
   end

   assign avs_waitrequest     = (avs_read | avs_write) & ~ack_r;
   assign avs_readdata        = rdata_r;
   assign trim_a_bank0        = trim_r[0];
   assign trim_a_bank1        = trim_r[1];
   assign trim_b_bank0        = trim_r[2];
   assign trim_b_bank1        = trim_r[3];
   assign filter_enable       = en_r;
   assign coef_share_enable   = ctrl_r[SHARE_BIT];
   assign filter_merge_enable = ctrl_r[MERGE_BIT];
   assign side_coef_weight    = ctrl_r[4:2];
   assign side_lsb_exp_neg    = exp_r;
   assign coef_a_tap0         = coef_a_r;
   assign coef_b_tap0         = coef_b_r;
   assign trim_ready          = (state_r == GTFC_READY) &&
                                (fuse_idx_r != 2'h0);
endmodule
`default_nettype wire

// [tb/gtfc_bank_properties.sv]
// checker: handshake and field relations of the gain/filter bank
`timescale 1ns/1ps
`default_nettype none
module gtfc_bank_properties
   import gtfc_pkg::*;
(
   input wire logic        clock,
   input wire logic        arst_n,
   input wire logic [13:0] avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic        avs_waitrequest,
   input wire logic [4:0]  trim_a_bank0,
   input wire logic        filter_enable,
   input wire logic        coef_share_enable,
   input wire logic        filter_merge_enable,
   input wire logic [2:0]  side_coef_weight,
   input wire logic [4:0]  side_lsb_exp_neg,
   input wire logic [11:0] coef_a_tap0,
   input wire logic [11:0] coef_b_tap0,
   input wire logic        trim_ready
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   logic        wr_ok;
   logic [11:0] a;
   assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
   assign a     = avs_address[11:0];

   chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("wait state longer than one cycle");
   chk_mode_decode: assert property (
      wr_ok && a == FILTER_CTRL_IDX |=>
      filter_enable == ($past(avs_writedata[1:0]) == MODE_ON))
      else $error("filter enable does not follow mode");
   chk_share_bit: assert property (
      wr_ok && a == FILTER_CTRL_IDX |=>
      coef_share_enable == $past(avs_writedata[6]))
      else $error("share output wrong");
   chk_merge_bit: assert property (
      wr_ok && a == FILTER_CTRL_IDX |=>
      filter_merge_enable == $past(avs_writedata[5]))
      else $error("merge output wrong");
   chk_side_weight: assert property (
      wr_ok && a == FILTER_CTRL_IDX |=>
      side_coef_weight == $past(avs_writedata[4:2]))
      else $error("side weight output wrong");
   chk_weight_exp: assert property (side_lsb_exp_neg == SCW_EXP_BIAS -
      ((side_coef_weight > SCW_MAX) ? {2'h0, SCW_MAX}
                                    : {2'h0, side_coef_weight}))
      else $error("lsb exponent wrong");
   chk_coef_b: assert property (
      $stable(coef_share_enable) && $stable(coef_a_tap0) |->
      coef_b_tap0 == (coef_share_enable ? coef_a_tap0 : COEF_RST))
      else $error("channel b coefficient wrong");
   chk_trim_write: assert property (
      wr_ok && trim_ready && a == FINE_GAIN_A0_IDX |=>
      trim_a_bank0 == $past(avs_writedata[4:0]))
      else $error("trim write lost");
   chk_fuse_ready: assert property ($rose(arst_n) |-> ##[0:6] trim_ready)
      else $error("fuse load too slow");
   chk_coef_write: assert property (
      wr_ok && avs_byteenable[1] && a == COEF_A_TAP0_IDX |=>
      coef_a_tap0 == $past(avs_writedata[11:0]))
      else $error("coefficient write lost");
endmodule
bind gtfc_bank gtfc_bank_properties i_gtfc_bank_properties (.*);
`default_nettype wire

// [tb/tb.sv]
// testbench: random and corner register traffic on the gain/filter bank
`timescale 1ns/1ps
`default_nettype none
module tb
   import gtfc_pkg::*;
;
   localparam logic [19:0] FUSE = 20'hb5a63; // arbitrary factory image
   logic        clock         = 1'b0;
   logic        arst_n        = 1'b0;
   logic [13:0] avs_address   = 14'h0000;
   logic        avs_read      = 1'b0;
   logic        avs_write     = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [19:0] trims;
   logic        fen, shr, mrg, rdy;
   logic [2:0]  scw;
   logic [4:0]  xn;
   logic [11:0] ca, cb;
   logic [31:0] q, d;
   logic [31:0] seed          = 32'h0001_153e;
   int          n_mismatch    = 0;
   int          num_checks    = 0;

   gtfc_bank #(.FUSE_TRIM_INIT(FUSE)) i_gtfc_bank (
      .clock(clock), .arst_n(arst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .trim_a_bank0(trims[4:0]), .trim_a_bank1(trims[9:5]),
      .trim_b_bank0(trims[14:10]), .trim_b_bank1(trims[19:15]),
      .filter_enable(fen), .coef_share_enable(shr),
      .filter_merge_enable(mrg), .side_coef_weight(scw),
      .side_lsb_exp_neg(xn), .coef_a_tap0(ca), .coef_b_tap0(cb),
      .trim_ready(rdy));

   always #5 clock = ~clock;

   // --------
   // helpers
   // --------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [4:0] exp_neg(input logic [2:0] s);
      return 5'h10 - ((s > 3'h6) ? 5'h6 : {2'h0, s});
   endfunction

   task automatic check(input string nm, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // held until waitrequest is sampled low, then one idle edge
   task automatic acc(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      avs_address <= {2'h0, a};
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clock);
      while (avs_waitrequest !== 1'b0) @(posedge clock);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clock);
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // --------
   // sequence
   // --------
   initial begin
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      acc(1'b0, FILTER_CTRL_IDX, 32'h0, q);
      check("ctrl reset", q, 32'h0);
      check("exp reset", {27'h0, xn}, 32'h10);
      for (int i = 0; i < 20 && rdy !== 1'b1; i++) @(posedge clock);
      for (int i = 0; i < 4; i++) begin
         acc(1'b0, FINE_GAIN_A0_IDX + 12'(i), 32'h0, q);
         check("fuse trim", q, {27'h0, FUSE[5*i +: 5]});
      end
      acc(1'b1, LINK_CTRL_IDX, 32'h0, q);
      for (int n = 0; n < 32; n++) begin
         d = rnd() & 32'h1f;
         acc(1'b1, FINE_GAIN_A0_IDX + 12'(n % 4), d, q);
         acc(1'b0, FINE_GAIN_A0_IDX + 12'(n % 4), 32'h0, q);
         check("trim read", q, d);
         check("trim port", {27'h0, trims[5*(n%4) +: 5]}, d);
         d = (rnd() & 32'h7c) | 32'(n % 4);
         // merged single channel setup, widest weight
         if (n == 1) d = 32'h7a;
         acc(1'b1, FILTER_CTRL_IDX, d, q);
         acc(1'b0, FILTER_CTRL_IDX, 32'h0, q);
         check("ctrl read", q, d);
         check("enable", {31'h0, fen}, {31'h0, d[1:0] == MODE_ON});
         check("share", {31'h0, shr}, {31'h0, d[6]});
         check("merge", {31'h0, mrg}, {31'h0, d[5]});
         check("weight", {27'h0, xn}, {27'h0, exp_neg(d[4:2])});
         // taps reloaded after each mode change
         d = (n == 0) ? 32'hfff : rnd() & 32'hfff;
         acc(1'b1, COEF_A_TAP0_IDX, d, q);
         acc(1'b0, COEF_A_TAP0_IDX, 32'h0, q);
         check("coef read", q, d & 32'h7ff);
         check("coef a", {20'h0, ca}, d);
         check("coef b", {20'h0, cb}, shr ? d : 32'h0);
      end
      acc(1'b1, 12'h3ff, 32'hff, q);
      acc(1'b0, 12'h3ff, 32'h0, q);
      check("unmapped", q, 32'h0);
      summarize();
   end

   initial begin
      repeat (5000) @(posedge clock);
      n_mismatch++;
      summarize();
   end
endmodule
`default_nettype wire
